// ### hdl/cbs_pkg.sv
/*
  Shared constants, types and helpers of the configuration bank switch controller.
  Assumes a single 40 MHz digital clock; step times are plain defaults to be tuned.
*/
package cbs_pkg;

  // ==========================================================================
  // Field widths
  localparam int ON_FIELD_W  = 4;
  localparam int OFF_FIELD_W = 3;
  localparam int TMR_W       = 16;

  // ==========================================================================
  // Timing: step times in their own unit, cycle counts derived (rounded up)
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ON_STEP_NS    = 1000;
  localparam int OFF_STEP_NS   = 8000;
  localparam int ON_STEP_CYC   = (ON_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OFF_STEP_CYC  = (OFF_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================================
  // Status encoding and reset values
  localparam logic STATUS_BANK_A   = 1'b1;
  localparam logic STATUS_BANK_B   = 1'b0;
  localparam logic STATUS_RESET    = STATUS_BANK_A;
  localparam logic SEL_FIRST_RESET = 1'b0;
  localparam logic SEL_SECOND_RST  = 1'b0;
  localparam logic OSC_EN_RESET    = 1'b0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {CBS_OFF, CBS_ON_A, CBS_ON_B} cbs_cfg_e;
  typedef enum logic {CBS_SCH_OFF, CBS_SCH_ON} cbs_sched_e;

  typedef struct packed {
    logic select_first_bank;
    logic select_second_bank;
    logic wake_osc_enable;
  } cbs_sel_s;

  typedef struct packed {
    logic [ON_FIELD_W-1:0]  on_time_a;
    logic [ON_FIELD_W-1:0]  on_time_b;
    logic [OFF_FIELD_W-1:0] off_time;
  } cbs_timing_s;

  // ==========================================================================
  // Duration in cycles of a field: (field + 1) steps
  function automatic logic [TMR_W-1:0] cbs_duration(input logic [ON_FIELD_W-1:0] field,
                                                    input int step_cyc);
    int tmp;
    tmp = (int'(field) + 1) * step_cyc;
    return tmp[TMR_W-1:0];
  endfunction : cbs_duration

endpackage : cbs_pkg

// ### hdl/cbs_edge_detect.sv
/*
  Rise and fall detector for a synchronous level.
  Assumes the input is already synchronous to clk.
*/
`timescale 1ns/1ps
module cbs_edge_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Level and edges
  input  wire logic level,
  input  wire logic reset_level,
  output logic      rise,
  output logic      fall
);
  logic level_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      level_q <= reset_level;
    else if (clk_en)
      level_q <= level;
  end

  assign rise = clk_en & level & ~level_q;
  assign fall = clk_en & ~level & level_q;
endmodule : cbs_edge_detect

// ### hdl/cbs_phase_timer.sv
/*
  Down counter for the on and off phases of the wake schedule.
  Assumes load is a one-cycle request; done pulses when the count expires.
*/
`timescale 1ns/1ps
module cbs_phase_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_q <= '0;
    else if (clk_en)
    begin
      if (load)
        cnt_q <= load_value;
      else if (cnt_q != '0)
        cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy = (cnt_q != '0);
  // Done must not look at load: the parent decides to reload from done
  assign done = clk_en & (cnt_q == W'(1));
endmodule : cbs_phase_timer

// ### hdl/cbs_bank_switch.sv
/*
  Configuration bank switch controller: picks which bank drives the receiver,
  alternates banks at wakeups and keeps the active bank status.
  Assumes all inputs are synchronous to clk; the SPI slave lives outside and
  reports a completed access by a pulse; the host keeps the pin and select rules.
*/
`timescale 1ns/1ps
module cbs_bank_switch
  import cbs_pkg::*;
#(
  parameter int ON_STEP  = cbs_pkg::ON_STEP_CYC,
  parameter int OFF_STEP = cbs_pkg::OFF_STEP_CYC
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  // Host pins
  input  wire logic                wake_pin,
  input  wire logic                wake_pin_driven,
  input  wire logic                wake_tied_high,
  input  wire logic                config_select_n,
  input  wire logic                spi_access_done,
  // Written configuration
  input  wire cbs_pkg::cbs_sel_s    sel_in,
  input  wire cbs_pkg::cbs_timing_s timing_in,
  // Receiver datapath
  input  wire logic                msg_active,
  // Results
  output logic                     active_bank_status,
  output logic                     receiver_on,
  output logic                     second_bank_drives,
  output cbs_pkg::cbs_sel_s         sel_applied
);
  import cbs_pkg::*;

  // ==========================================================================
  // Declarations
  cbs_sel_s           sel_q;
  logic               status_q;
  logic               status_d;
  cbs_cfg_e           cfg_q;
  cbs_cfg_e           cfg_d;
  cbs_sched_e         sched_q;
  logic               osc_mode_q;
  logic               cfg_rise;
  logic               wake_fall;
  logic               direct_mode;
  logic               pin_mode;
  logic               osc_mode;
  logic               alternating;
  logic               fixed_status;
  logic               host_forces;
  logic               want_on;
  logic               tmr_load;
  logic [TMR_W-1:0]   tmr_value;
  logic               tmr_busy;
  logic               tmr_done;
  logic               sched_on_end;

  // ==========================================================================
  // Edge detection
  cbs_edge_detect u_cfg_edge (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .level       (config_select_n),
    .reset_level (1'b1),
    .rise        (cfg_rise),
    .fall        ()
  );

  cbs_edge_detect u_wake_edge (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .level       (wake_pin),
    .reset_level (1'b0),
    .rise        (),
    .fall        (wake_fall)
  );

  // ==========================================================================
  // Applied selection: SPI writes stay pending until configuration mode ends
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_q.select_first_bank  <= SEL_FIRST_RESET;
      sel_q.select_second_bank <= SEL_SECOND_RST;
      sel_q.wake_osc_enable    <= OSC_EN_RESET;
    end
    else if (clk_en && cfg_rise)
      sel_q <= sel_in;
  end

  // ==========================================================================
  // Mode decode
  assign osc_mode    = sel_q.wake_osc_enable;
  assign direct_mode = ~osc_mode & wake_tied_high;
  assign pin_mode    = ~osc_mode & ~wake_tied_high;

  // Both selects in direct control would be illegal; bank A is the safe answer
  assign alternating = sel_q.select_first_bank & sel_q.select_second_bank
                     & ~direct_mode;

  always_comb
  begin
    if (!sel_q.select_second_bank)
      fixed_status = STATUS_BANK_A;
    else if (!sel_q.select_first_bank)
      fixed_status = STATUS_BANK_B;
    else
      fixed_status = STATUS_BANK_A;
  end

  // Host drive of the pin wins over the oscillator
  assign host_forces = osc_mode & wake_pin_driven;

  // ==========================================================================
  // Wake schedule: free-running off/on sequence, never stretched by the
  // state actually taken, so a held state cannot shift later phases
  assign sched_on_end = (sched_q == CBS_SCH_ON) & tmr_done;

  always_comb
  begin
    tmr_load  = 1'b0;
    tmr_value = '0;
    if (osc_mode && alternating && spi_access_done)
    begin
      tmr_load  = 1'b1;
      tmr_value = cbs_duration(timing_in.on_time_a, ON_STEP);
    end
    else if (osc_mode && (tmr_done || !tmr_busy))
    begin
      tmr_load = 1'b1;
      if (sched_q == CBS_SCH_OFF && tmr_done)
      begin
        if (status_q == STATUS_BANK_A)
          tmr_value = cbs_duration(timing_in.on_time_a, ON_STEP);
        else
          tmr_value = cbs_duration(timing_in.on_time_b, ON_STEP);
      end
      else
        tmr_value = cbs_duration(ON_FIELD_W'(timing_in.off_time), OFF_STEP);
    end
  end

  cbs_phase_timer #(
    .W (TMR_W)
  ) u_timer (
    .clk        (clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .load       (tmr_load),
    .load_value (tmr_value),
    .busy       (tmr_busy),
    .done       (tmr_done)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sched_q    <= CBS_SCH_OFF;
      osc_mode_q <= OSC_EN_RESET;
    end
    else if (clk_en)
    begin
      osc_mode_q <= osc_mode;
      if (!osc_mode)
        sched_q <= CBS_SCH_OFF;
      else if (alternating && spi_access_done)
        sched_q <= CBS_SCH_ON;
      else if (tmr_load && tmr_done)
        sched_q <= (sched_q == CBS_SCH_OFF) ? CBS_SCH_ON : CBS_SCH_OFF;
      else if (!osc_mode_q)
        sched_q <= CBS_SCH_OFF;
    end
  end

  // ==========================================================================
  // Active bank status
  always_comb
  begin
    status_d = status_q;
    if (!alternating)
      status_d = fixed_status;
    else if (spi_access_done)
      status_d = STATUS_BANK_A;
    else if (pin_mode && wake_fall)
      status_d = ~status_q;
    else if (osc_mode && sched_on_end && !(host_forces && wake_pin))
      status_d = ~status_q;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      status_q <= STATUS_RESET;
    else if (clk_en)
      status_q <= status_d;
  end

  // ==========================================================================
  // Receiver configuration state
  always_comb
  begin
    if (direct_mode)
      want_on = 1'b1;
    else if (pin_mode)
      want_on = wake_pin;
    else if (host_forces)
      want_on = wake_pin;
    else
      want_on = (sched_q == CBS_SCH_ON);
  end

  always_comb
  begin
    cfg_d = cfg_q;
    // A message being received pins the current bank state
    if (cfg_q != CBS_OFF && msg_active)
      cfg_d = cfg_q;
    else if (!want_on)
      cfg_d = CBS_OFF;
    else if (status_d == STATUS_BANK_A)
      cfg_d = CBS_ON_A;
    else
      cfg_d = CBS_ON_B;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      cfg_q <= CBS_OFF;
    else if (clk_en)
      cfg_q <= cfg_d;
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      active_bank_status <= STATUS_RESET;
      receiver_on        <= 1'b0;
      second_bank_drives <= 1'b0;
      sel_applied        <= '0;
    end
    else if (clk_en)
    begin
      active_bank_status <= status_d;
      receiver_on        <= (cfg_d != CBS_OFF);
      second_bank_drives <= (cfg_d == CBS_ON_B);
      sel_applied        <= cfg_rise ? sel_in : sel_q;
    end
  end

endmodule : cbs_bank_switch

// ### verif/cbs_bank_switch_props.sv
/*
  Assertion checker of the bank switch controller, bound to every instance.
  Assumes clk_en is held high, so an edge of a level spans one clock.
*/
`timescale 1ns/1ps
module cbs_bank_switch_props
  import cbs_pkg::*;
#(
  parameter int ON_STEP  = 2,
  parameter int OFF_STEP = 3
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              clk_en,
  // Host side
  input wire logic              wake_pin,
  input wire logic              config_select_n,
  input wire logic              spi_access_done,
  input wire logic              msg_active,
  input wire cbs_pkg::cbs_sel_s sel_in,
  // Results
  input wire logic              active_bank_status,
  input wire logic              receiver_on,
  input wire logic              second_bank_drives,
  input wire cbs_pkg::cbs_sel_s sel_applied
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic osc_mode = sel_applied.wake_osc_enable;
  wire logic alt_mode = sel_applied.select_first_bank & sel_applied.select_second_bank;
  sequence s_steady_high;
    !osc_mode && wake_pin && !msg_active && !$rose(config_select_n);
  endsequence
  sequence s_alt_fall;
    !osc_mode && alt_mode && clk_en && $fell(wake_pin) && !spi_access_done;
  endsequence

  a_reset_state: assert property (disable iff (1'b0) reset |=>
    active_bank_status && !receiver_on && !second_bank_drives && sel_applied == '0)
    else $error("outputs not at reset values");
  a_sel_capture: assert property (clk_en && $rose(config_select_n) |=>
    sel_applied == $past(sel_in))
    else $error("selection not applied at config release");
  a_sel_hold: assert property (!(clk_en && $rose(config_select_n)) |=> $stable(sel_applied))
    else $error("selection changed without config release");
  a_bank_a_on: assert property (s_steady_high ##0 !sel_applied.select_second_bank |=>
    receiver_on && !second_bank_drives && active_bank_status)
    else $error("bank A not running with status 1");
  a_bank_b_on: assert property (s_steady_high ##0 !sel_applied.select_first_bank
    ##0 sel_applied.select_second_bank |=> receiver_on && second_bank_drives && !active_bank_status)
    else $error("bank B not running with status 0");
  a_pin_low_off: assert property (!osc_mode && !wake_pin && !msg_active |=> !receiver_on)
    else $error("receiver on with pin low and no message");
  a_fall_toggle: assert property (s_alt_fall |=> active_bank_status != $past(active_bank_status))
    else $error("status not inverted at pin fall");
  a_spi_restart: assert property (alt_mode && clk_en && spi_access_done |=> active_bank_status)
    else $error("access did not restart at bank A");
  a_b_needs_on: assert property (second_bank_drives |-> receiver_on)
    else $error("bank B drives while receiver off");
endmodule : cbs_bank_switch_props

bind cbs_bank_switch cbs_bank_switch_props #(.ON_STEP(ON_STEP), .OFF_STEP(OFF_STEP)) u_props (
  .clk(clk), .reset(reset), .clk_en(clk_en), .wake_pin(wake_pin),
  .config_select_n(config_select_n), .spi_access_done(spi_access_done),
  .msg_active(msg_active), .sel_in(sel_in), .active_bank_status(active_bank_status),
  .receiver_on(receiver_on), .second_bank_drives(second_bank_drives),
  .sel_applied(sel_applied)
);

// ### verif/cbs_host_model.sv
/*
  Host model: drives the wake pin, config select, access pulse and selection.
  Assumes one calling process; a released pin shows a changing pattern.
*/
`timescale 1ns/1ps
module cbs_host_model
  import cbs_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Host pins
  output wire logic         wake_pin,
  output logic              wake_pin_driven,
  output logic              wake_tied_high,
  output logic              config_select_n,
  output logic              spi_access_done,
  output cbs_pkg::cbs_sel_s sel_in
);
  // ==========================================================================
  // Pin level
  logic level_q;
  logic noise_q;
  // Undriven pin has no level of its own; the oscillator owns it
  assign wake_pin = (wake_pin_driven | wake_tied_high) ? level_q : noise_q;
  always @(posedge clk)
    noise_q <= ~noise_q;

  initial
  begin
    {level_q, noise_q, wake_pin_driven, wake_tied_high} = 4'hf;
    {config_select_n, spi_access_done, sel_in} = 5'h10;
  end

  // ==========================================================================
  // Tasks
  task automatic drive(input logic tied, input logic level);
    @(posedge clk);
    wake_tied_high  <= tied;
    wake_pin_driven <= 1'b1;
    level_q         <= level;
  endtask : drive

  task automatic release_pin();
    @(posedge clk);
    wake_pin_driven <= 1'b0;
  endtask : release_pin

  // Both selects in direct control only when a test asks for it
  task automatic open_cfg(input cbs_sel_s s);
    @(posedge clk);
    wake_pin_driven <= 1'b1;
    level_q         <= 1'b1;
    config_select_n <= 1'b0;
    @(posedge clk);
    sel_in          <= s;
    spi_access_done <= 1'b1;
    @(posedge clk);
    spi_access_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : open_cfg

  task automatic close_cfg();
    @(posedge clk);
    config_select_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : close_cfg
endmodule : cbs_host_model

// ### verif/cbs_bank_switch_tb_top.sv
/*
  Testbench of the bank switch controller: a table of direct and pin cases,
  then hand tests of alternation, message hold and oscillator timing.
  Assumes the host model drives the pins; steps shortened to 2 and 3 cycles.
*/
`timescale 1ns/1ps
module cbs_bank_switch_tb_top;
  import cbs_pkg::*;
  localparam int ONS = 2;
  localparam int OFS = 3;
  typedef struct packed {logic tied; cbs_sel_s s; logic wake; logic on; logic b;} cbs_row_s;
  localparam cbs_row_s ROWS [8] = '{
    '{1'b1, 3'h0, 1'b1, 1'b1, 1'b0}, '{1'b1, 3'h4, 1'b1, 1'b1, 1'b0},
    '{1'b1, 3'h2, 1'b1, 1'b1, 1'b1}, '{1'b1, 3'h6, 1'b1, 1'b1, 1'b0},
    '{1'b0, 3'h2, 1'b1, 1'b1, 1'b1}, '{1'b0, 3'h2, 1'b0, 1'b0, 1'b0},
    '{1'b0, 3'h4, 1'b1, 1'b1, 1'b0}, '{1'b0, 3'h0, 1'b0, 1'b0, 1'b0}};

  logic        clk;
  logic        reset;
  logic        msg_active;
  cbs_timing_s timing_in;
  wire logic   wake_pin;
  wire logic   wake_pin_driven;
  wire logic   wake_tied_high;
  wire logic   config_select_n;
  wire logic   spi_access_done;
  wire cbs_sel_s sel_in;
  cbs_sel_s    sel_applied;
  logic        active_bank_status;
  logic        receiver_on;
  logic        second_bank_drives;
  int          miscompares;
  int          cmp_count;

  cbs_host_model host (.clk(clk), .wake_pin(wake_pin), .wake_pin_driven(wake_pin_driven),
    .wake_tied_high(wake_tied_high), .config_select_n(config_select_n),
    .spi_access_done(spi_access_done), .sel_in(sel_in));
  cbs_bank_switch #(.ON_STEP(ONS), .OFF_STEP(OFS)) uut (.clk(clk), .reset(reset),
    .clk_en(1'b1), .wake_pin(wake_pin), .wake_pin_driven(wake_pin_driven),
    .wake_tied_high(wake_tied_high), .config_select_n(config_select_n),
    .spi_access_done(spi_access_done), .sel_in(sel_in), .timing_in(timing_in),
    .msg_active(msg_active), .active_bank_status(active_bank_status),
    .receiver_on(receiver_on), .second_bank_drives(second_bank_drives),
    .sel_applied(sel_applied));

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle

  task automatic tick(inout int n);
    settle(1);
    n++;
  endtask : tick

  // Waits out any running pulse, then times the gap and the next on pulse
  task automatic measure(output int len, output int gap, output logic bank);
    int n;
    n = 0;
    while (receiver_on === 1'b1 && n < 500) tick(n);
    gap = 0;
    while (receiver_on !== 1'b1 && gap < 500) tick(gap);
    bank = second_bank_drives;
    len = 0;
    while (receiver_on === 1'b1 && len < 500) tick(len);
  endtask : measure

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Clock, watchdog, tests
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    cbs_row_s r;
    logic s0, b1, b2;
    int l1, l2, g1, g2;
    reset = 1'b1;
    msg_active = 1'b0;
    timing_in = '{4'h1, 4'h4, 3'h0};
    settle(8);
    check("reset out", {active_bank_status, receiver_on, second_bank_drives}, 8'h04);
    check("reset sel", sel_applied, 8'h00);
    @(posedge clk);
    reset <= 1'b0;
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      host.drive(r.tied, 1'b1);
      host.open_cfg(r.s);
      host.close_cfg();
      host.drive(r.tied, r.wake);
      settle(2);
      check("on", receiver_on, r.on);
      check("bank", second_bank_drives, r.b);
      if (r.on)
        check("status", active_bank_status, !r.b);
    end
    $display("table done");
    host.drive(1'b1, 1'b1);
    host.open_cfg(3'h2);
    settle(1);
    check("before release", second_bank_drives, 8'h00);
    host.close_cfg();
    settle(1);
    check("after release", second_bank_drives, 8'h01);
    $display("release test done");
    host.drive(1'b0, 1'b1);
    host.open_cfg(3'h6);
    host.close_cfg();
    settle(2);
    s0 = active_bank_status;
    check("alt high", {receiver_on, second_bank_drives}, {1'b1, !s0});
    host.drive(1'b0, 1'b0);
    settle(2);
    check("alt fall", {receiver_on, active_bank_status}, {1'b0, !s0});
    host.drive(1'b0, 1'b1);
    settle(2);
    check("alt next", {receiver_on, second_bank_drives}, {1'b1, s0});
    @(posedge clk);
    msg_active <= 1'b1;
    host.drive(1'b0, 1'b0);
    settle(4);
    check("hold", {receiver_on, second_bank_drives, active_bank_status}, {1'b1, s0, s0});
    @(posedge clk);
    msg_active <= 1'b0;
    settle(2);
    check("hold end", receiver_on, 8'h00);
    host.drive(1'b0, 1'b1);
    host.open_cfg(3'h6);
    host.close_cfg();
    settle(1);
    check("restart", {receiver_on, second_bank_drives, active_bank_status}, 8'h05);
    $display("pin alternation done");
    host.open_cfg(3'h7);
    host.close_cfg();
    s0 = active_bank_status;
    settle(60);
    check("forced", {receiver_on, second_bank_drives, active_bank_status}, {1'b1, !s0, s0});
    host.release_pin();
    measure(l1, g1, b1);
    measure(l1, g1, b1);
    measure(l2, g2, b2);
    check("osc alt", b2, !b1);
    check("on spans", 8'(b1 ? l1 - l2 : l2 - l1), 8'((4 - 1) * ONS));
    check("off spans", 8'(g2), 8'(g1));
    $display("oscillator done");
    give_verdict();
  end
endmodule : cbs_bank_switch_tb_top
